// [src/imd_regs.vh]
`ifndef IMD_REGS_VH
`define IMD_REGS_VH

// operation codes on issue_op
`define IMD_OP_ADD            5'h00
`define IMD_OP_SUB            5'h01
`define IMD_OP_AND            5'h02
`define IMD_OP_OR             5'h03
`define IMD_OP_XOR            5'h04
`define IMD_OP_NOR            5'h05
`define IMD_OP_SLL            5'h06
`define IMD_OP_SRL            5'h07
`define IMD_OP_SRA            5'h08
`define IMD_OP_WPROD          5'h09
`define IMD_OP_WPROD_U        5'h0A
`define IMD_OP_PACC           5'h0B
`define IMD_OP_PACC_U         5'h0C
`define IMD_OP_PROD_GPR       5'h0D
`define IMD_OP_DPROD          5'h0E
`define IMD_OP_DPROD_U        5'h0F
`define IMD_OP_WQUOT          5'h10
`define IMD_OP_WQUOT_U        5'h11
`define IMD_OP_DQUOT          5'h12
`define IMD_OP_DQUOT_U        5'h13
`define IMD_OP_MOVE_UPPER     5'h14
`define IMD_OP_MOVE_LOWER     5'h15

// multiply/divide timing in pipeline clocks
`define IMD_LAT_W16           7'h03
`define IMD_REP_W16           7'h02
`define IMD_LAT_W32           7'h04
`define IMD_REP_W32           7'h03
`define IMD_STL_G16           7'h01
`define IMD_STL_G32           7'h02
`define IMD_LAT_DPROD         7'h06
`define IMD_REP_DPROD         7'h05
`define IMD_LAT_WQUOT         7'h24
`define IMD_REP_WQUOT         7'h24
`define IMD_LAT_DQUOT         7'h44
`define IMD_REP_DQUOT         7'h44

// pending result kinds
`define IMD_KIND_SET          2'h0
`define IMD_KIND_ACC          2'h1
`define IMD_KIND_GPR          2'h2

// counter helpers
`define IMD_CNT_ZERO          7'h00
`define IMD_CNT_ONE           7'h01
`define IMD_CNT_TWO           7'h02
`define IMD_RST_READY         1'b1

`endif

// [src/imd_regfile.v]
`timescale 1ns/1ps
`include "imd_regs.vh"
// 32 x 64 register store, two registered read ports, one write port
module imd_regfile (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [4:0]  ra_addr,
  input  wire [4:0]  rb_addr,
  output reg  [63:0] ra_data,
  output reg  [63:0] rb_data,
  input  wire        wr_en,
  input  wire [4:0]  wr_addr,
  input  wire [63:0] wr_data
);
  reg [63:0] mem [0:31];   // storage, no reset like any ram

  // write port
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read ports; same-cycle write is forwarded so a reader never sees stale data
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ra_data <= 64'h0000000000000000;
      rb_data <= 64'h0000000000000000;
    end else begin
      ra_data <= (wr_en && wr_addr == ra_addr) ? wr_data : mem[ra_addr];
      rb_data <= (wr_en && wr_addr == rb_addr) ? wr_data : mem[rb_addr];
    end
  end
endmodule

// [src/imd_datapath.v]
`timescale 1ns/1ps
`include "imd_regs.vh"
// integer execute datapath: register file, alu, multiply/divide unit
module imd_datapath (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        issue_valid,
  input  wire [4:0]  issue_op,
  input  wire [4:0]  issue_rs,
  input  wire [4:0]  issue_rt,
  input  wire [4:0]  issue_rd,
  output reg         ready,
  output reg         md_ready,
  output reg         result_ready,
  output reg         wb_valid,
  output reg  [4:0]  wb_rd,
  output reg  [63:0] wb_data,
  output reg  [63:0] upper_result,
  output reg  [63:0] lower_result
);
  // multiply/divide class
  function is_md;
    input [4:0] op;
    begin
      is_md = (op >= `IMD_OP_WPROD) && (op <= `IMD_OP_DQUOT_U);
    end
  endfunction

  // result register read class
  function is_mv;
    input [4:0] op;
    begin
      is_mv = (op == `IMD_OP_MOVE_UPPER) || (op == `IMD_OP_MOVE_LOWER);
    end
  endfunction

  // sign extend a word to a doubleword
  function [63:0] sext;
    input [31:0] w;
    begin
      sext = {{32{w[31]}}, w};
    end
  endfunction

  // operand fits 16 bits, signed or unsigned view
  function fits16;
    input [31:0] w;
    input        sgn;
    begin
      fits16 = sgn ? (w[31:15] == {17{w[15]}}) : (w[31:16] == 16'h0000);
    end
  endfunction

  // counter step toward zero
  function [6:0] dec;
    input [6:0] c;
    begin
      dec = (c != `IMD_CNT_ZERO) ? c - `IMD_CNT_ONE : `IMD_CNT_ZERO;
    end
  endfunction

  reg         ex_valid;     // op in execute stage
  reg  [4:0]  ex_op;        // its opcode
  reg  [4:0]  ex_rs;        // source indices for bypass compare
  reg  [4:0]  ex_rt;
  reg  [4:0]  ex_rd;        // destination
  reg  [6:0]  rep_cnt;      // cycles until unit takes a new op
  reg  [6:0]  stl_cnt;      // issue stall for product_to_gpr_op
  reg  [6:0]  pend_cnt;     // cycles until pending result commits
  reg  [1:0]  pend_kind;    // how the pending result commits
  reg  [63:0] pend_upper;   // pending upper half or product high
  reg  [63:0] pend_lower;   // pending lower half or product low
  reg  [4:0]  pend_rd;      // gpr target of product_to_gpr_op
  wire [63:0] rf_a;         // registered read data
  wire [63:0] rf_b;

  // register file; write port is the writeback register
  imd_regfile u_rf (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ra_addr (issue_rs),
    .rb_addr (issue_rt),
    .ra_data (rf_a),
    .rb_data (rf_b),
    .wr_en   (wb_valid),
    .wr_addr (wb_rd),
    .wr_data (wb_data)
  );

  wire accept = issue_valid && ready && (!is_md(issue_op) || md_ready) &&
                (!is_mv(issue_op) || result_ready);
  wire launch = ex_valid && is_md(ex_op);
  wire commit = (pend_cnt == `IMD_CNT_ONE);

  // bypass from the writeback register into execute
  wire [63:0] opa = (wb_valid && wb_rd == ex_rs) ? wb_data : rf_a;
  wire [63:0] opb = (wb_valid && wb_rd == ex_rt) ? wb_data : rf_b;

  reg         sgn;          // signed variant
  reg         short_ops;    // both operands fit 16 bits
  reg  [63:0] wprod;        // word product
  reg  [127:0] dprod;       // doubleword product
  reg  [63:0] wq_a;         // word divide operands, extended
  reg  [63:0] wq_b;
  reg  [63:0] wq_q;         // wide signed word quotient and remainder
  reg  [63:0] wq_r;
  reg  [63:0] alu_res;      // single-cycle result
  reg  [6:0]  lat;          // chosen latency, repeat, stall
  reg  [6:0]  rep;
  reg  [6:0]  stl;
  reg  [1:0]  kind;
  reg  [63:0] r_upper;
  reg  [63:0] r_lower;
  reg  [63:0] acc;          // accumulate sum

  // execute: adder, logic unit, and unit operand preparation
  always @* begin
    sgn   = !(ex_op == `IMD_OP_WPROD_U || ex_op == `IMD_OP_PACC_U ||
              ex_op == `IMD_OP_DPROD_U || ex_op == `IMD_OP_WQUOT_U ||
              ex_op == `IMD_OP_DQUOT_U);
    short_ops = fits16(opa[31:0], sgn) && fits16(opb[31:0], sgn);
    wprod = (sgn ? sext(opa[31:0]) : {32'h00000000, opa[31:0]}) *
            (sgn ? sext(opb[31:0]) : {32'h00000000, opb[31:0]});
    dprod = (sgn ? {{64{opa[63]}}, opa} : {64'h0000000000000000, opa}) *
            (sgn ? {{64{opb[63]}}, opb} : {64'h0000000000000000, opb});
    wq_a  = sgn ? sext(opa[31:0]) : {32'h00000000, opa[31:0]};
    wq_b  = sgn ? sext(opb[31:0]) : {32'h00000000, opb[31:0]};
    // adder and logic unit, both one cycle
    case (ex_op)
      `IMD_OP_ADD:        alu_res = opa + opb;
      `IMD_OP_SUB:        alu_res = opa - opb;
      `IMD_OP_AND:        alu_res = opa & opb;
      `IMD_OP_OR:         alu_res = opa | opb;
      `IMD_OP_XOR:        alu_res = opa ^ opb;
      `IMD_OP_NOR:        alu_res = ~(opa | opb);
      `IMD_OP_SLL:        alu_res = opa << opb[5:0];
      `IMD_OP_SRL:        alu_res = opa >> opb[5:0];
      `IMD_OP_SRA:        alu_res = $signed(opa) >>> opb[5:0];
      `IMD_OP_MOVE_UPPER: alu_res = upper_result;
      `IMD_OP_MOVE_LOWER: alu_res = lower_result;
      default:            alu_res = 64'h0000000000000000; // unknown op writes zero
    endcase
  end

  // multiply/divide selection of timing and result
  always @* begin
    lat     = short_ops ? `IMD_LAT_W16 : `IMD_LAT_W32;
    rep     = short_ops ? `IMD_REP_W16 : `IMD_REP_W32;
    stl     = `IMD_CNT_ZERO;
    // divided at 64 bits so most-negative over minus one stays in range
    wq_q    = $signed(wq_a) / $signed(wq_b);
    wq_r    = $signed(wq_a) % $signed(wq_b);
    kind    = `IMD_KIND_SET;
    r_upper = sext(wprod[63:32]);
    r_lower = sext(wprod[31:0]);
    case (ex_op)
      `IMD_OP_PACC, `IMD_OP_PACC_U: begin
        kind    = `IMD_KIND_ACC;
        r_upper = {32'h00000000, wprod[63:32]};
        r_lower = {32'h00000000, wprod[31:0]};
      end
      `IMD_OP_PROD_GPR: begin
        kind = `IMD_KIND_GPR;
        stl  = short_ops ? `IMD_STL_G16 : `IMD_STL_G32;
      end
      `IMD_OP_DPROD, `IMD_OP_DPROD_U: begin
        lat     = `IMD_LAT_DPROD;
        rep     = `IMD_REP_DPROD;
        r_upper = dprod[127:64];
        r_lower = dprod[63:0];
      end
      `IMD_OP_WQUOT, `IMD_OP_WQUOT_U: begin
        lat = `IMD_LAT_WQUOT;
        rep = `IMD_REP_WQUOT;
        // zero divisor: quotient all ones, remainder is the dividend
        if (wq_b == 64'h0000000000000000) begin
          r_lower = 64'hFFFFFFFFFFFFFFFF;
          r_upper = wq_a;
        end else if (sgn) begin
          r_lower = sext(wq_q[31:0]);
          r_upper = sext(wq_r[31:0]);
        end else begin
          r_lower = sext(wq_a[31:0] / wq_b[31:0]);
          r_upper = sext(wq_a[31:0] % wq_b[31:0]);
        end
      end
      `IMD_OP_DQUOT, `IMD_OP_DQUOT_U: begin
        lat = `IMD_LAT_DQUOT;
        rep = `IMD_REP_DQUOT;
        if (opb == 64'h0000000000000000) begin
          r_lower = 64'hFFFFFFFFFFFFFFFF;
          r_upper = opa;
        end else if (sgn) begin
          r_lower = $signed(opa) / $signed(opb);
          r_upper = $signed(opa) % $signed(opb);
        end else begin
          r_lower = opa / opb;
          r_upper = opa % opb;
        end
      end
      default: begin
        kind = `IMD_KIND_SET; // plain word product
      end
    endcase
    // accumulate works on the 64-bit pair of low words, atomically at commit
    acc = {upper_result[31:0], lower_result[31:0]} +
          {pend_upper[31:0], pend_lower[31:0]};
  end

  wire [6:0] next_rep  = launch ? rep - `IMD_CNT_TWO : dec(rep_cnt);
  wire [6:0] next_stl  = (launch && stl != `IMD_CNT_ZERO) ? stl - `IMD_CNT_ONE :
                         dec(stl_cnt);
  wire [6:0] next_pend = launch ? lat - `IMD_CNT_TWO : dec(pend_cnt);

  // pipeline stage, unit counters and interlock flags
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ex_valid     <= 1'b0;
      ex_op        <= `IMD_OP_ADD;
      ex_rs        <= 5'h00;
      ex_rt        <= 5'h00;
      ex_rd        <= 5'h00;
      rep_cnt      <= `IMD_CNT_ZERO;
      stl_cnt      <= `IMD_CNT_ZERO;
      pend_cnt     <= `IMD_CNT_ZERO;
      pend_kind    <= `IMD_KIND_SET;
      pend_upper   <= 64'h0000000000000000;
      pend_lower   <= 64'h0000000000000000;
      pend_rd      <= 5'h00;
      ready        <= `IMD_RST_READY;
      md_ready     <= `IMD_RST_READY;
      result_ready <= `IMD_RST_READY;
    end else begin
      // issue into execute, one op per clock
      ex_valid <= accept;
      ex_op    <= issue_op;
      ex_rs    <= issue_rs;
      ex_rt    <= issue_rt;
      ex_rd    <= issue_rd;
      rep_cnt  <= next_rep;
      stl_cnt  <= next_stl;
      pend_cnt <= next_pend;
      // single pending slot suffices: repeat never lets a launch beat a commit
      if (launch) begin
        pend_kind  <= kind;
        pend_upper <= r_upper;
        pend_lower <= r_lower;
        pend_rd    <= ex_rd;
      end
      // flags look one cycle ahead so they can come from flops
      ready        <= !(accept && issue_op == `IMD_OP_PROD_GPR) &&
                      (next_stl == `IMD_CNT_ZERO);
      md_ready     <= !(accept && is_md(issue_op)) &&
                      (next_rep == `IMD_CNT_ZERO);
      result_ready <= !(accept && is_md(issue_op)) &&
                      (next_pend <= `IMD_CNT_ONE);
    end
  end

  // writeback register and result registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_valid     <= 1'b0;
      wb_rd        <= 5'h00;
      wb_data      <= 64'h0000000000000000;
      upper_result <= 64'h0000000000000000;
      lower_result <= 64'h0000000000000000;
    end else begin
      // stall window keeps execute empty when a product_to_gpr_op commits
      if (ex_valid && !is_md(ex_op)) begin
        wb_valid <= 1'b1;
        wb_rd    <= ex_rd;
        wb_data  <= alu_res;
      end else if (commit && pend_kind == `IMD_KIND_GPR) begin
        wb_valid <= 1'b1;
        wb_rd    <= pend_rd;
        wb_data  <= pend_lower;
      end else begin
        wb_valid <= 1'b0;
      end
      if (commit && pend_kind == `IMD_KIND_SET) begin
        upper_result <= pend_upper;
        lower_result <= pend_lower;
      end else if (commit && pend_kind == `IMD_KIND_ACC) begin
        upper_result <= sext(acc[63:32]);
        lower_result <= sext(acc[31:0]);
      end
    end
  end
endmodule

// [tb/imd_datapath_assertions.sv]
`timescale 1ns/1ps
`include "imd_regs.vh"
// port-level timing checks of the execute datapath
module imd_datapath_assertions (
  input wire        clk_sys,
  input wire        rst,
  input wire        issue_valid,
  input wire [4:0]  issue_op,
  input wire [4:0]  issue_rs,
  input wire [4:0]  issue_rt,
  input wire [4:0]  issue_rd,
  input wire        ready,
  input wire        md_ready,
  input wire        result_ready,
  input wire        wb_valid,
  input wire [4:0]  wb_rd,
  input wire [63:0] wb_data,
  input wire [63:0] upper_result,
  input wire [63:0] lower_result
);
  // op classes and the take condition
  wire md  = issue_op >= `IMD_OP_WPROD && issue_op <= `IMD_OP_DQUOT_U;
  wire mv  = issue_op == `IMD_OP_MOVE_UPPER || issue_op == `IMD_OP_MOVE_LOWER;
  wire tk  = issue_valid && ready && (!md || md_ready) && (!mv || result_ready);
  wire gpr = tk && issue_op == `IMD_OP_PROD_GPR;
  wire dp  = tk && (issue_op == `IMD_OP_DPROD || issue_op == `IMD_OP_DPROD_U);
  wire wq  = tk && (issue_op == `IMD_OP_WQUOT || issue_op == `IMD_OP_WQUOT_U);
  wire dq  = tk && (issue_op == `IMD_OP_DQUOT || issue_op == `IMD_OP_DQUOT_U);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_alu_wb: assert property (
    tk && !md && !mv |-> ##2 wb_valid && wb_rd == $past(issue_rd, 2))
    else $error("alu result late or to wrong register");
  a_move_upper: assert property (
    tk && issue_op == `IMD_OP_MOVE_UPPER |-> ##2 wb_data == $past(upper_result, 1))
    else $error("move from upper copied wrong value");
  a_move_lower: assert property (
    tk && issue_op == `IMD_OP_MOVE_LOWER |-> ##2 wb_data == $past(lower_result, 1))
    else $error("move from lower copied wrong value");
  a_md_busy: assert property (tk && md |=> !md_ready)
    else $error("md unit free right after issue");
  a_read_lock: assert property (tk && md && !gpr |=> !result_ready)
    else $error("result read open while result pending");
  a_gpr_stall: assert property (gpr |=> !ready)
    else $error("product to register did not stall");
  a_no_stall: assert property (tk && !gpr |=> ready)
    else $error("stall after a non stalling op");
  a_gpr_keep: assert property (gpr |-> ##2 $stable(lower_result) [*3])
    else $error("product to register touched lower result");
  a_dprod_rep: assert property (dp |-> ##4 !md_ready ##1 md_ready)
    else $error("doubleword product repeat wrong");
  a_wquot_rep: assert property (wq |-> ##35 !md_ready ##1 md_ready)
    else $error("word quotient repeat wrong");
  a_dquot_rep: assert property (dq |-> ##67 !md_ready ##1 md_ready)
    else $error("doubleword quotient repeat wrong");
endmodule
bind imd_datapath imd_datapath_assertions u_chk (.clk_sys(clk_sys), .rst(rst),
  .issue_valid(issue_valid), .issue_op(issue_op), .issue_rs(issue_rs), .issue_rt(issue_rt),
  .issue_rd(issue_rd), .ready(ready), .md_ready(md_ready), .result_ready(result_ready),
  .wb_valid(wb_valid), .wb_rd(wb_rd), .wb_data(wb_data), .upper_result(upper_result),
  .lower_result(lower_result));

// [tb/imd_pipe_model.sv]
`timescale 1ns/1ps
`include "imd_regs.vh"
// issue stage: presents an op and holds it until the datapath takes it
module imd_pipe_model (
  input  wire       clk_sys,
  input  wire       ready,
  input  wire       md_ready,
  input  wire       result_ready,
  output reg        issue_valid,
  output reg  [4:0] issue_op,
  output reg  [4:0] issue_rs,
  output reg  [4:0] issue_rt,
  output reg  [4:0] issue_rd
);
  initial begin
    issue_valid = 1'b0;
    {issue_op, issue_rs, issue_rt, issue_rd} = 20'h00000;
  end
  // released fields flip so a stale operand never looks held
  task idle;
    begin
      issue_valid = 1'b0;
      {issue_op, issue_rs, issue_rt, issue_rd} = ~{issue_op, issue_rs, issue_rt, issue_rd};
    end
  endtask
  // called just after an edge; returns just after the taking edge
  task issue(input logic [4:0] op, rs, rt, rd, input int gap);
    reg ok;
    begin
      if (gap > 0) idle();
      repeat (gap) begin
        @(posedge clk_sys);
        #1;
      end
      issue_valid = 1'b1;
      {issue_op, issue_rs, issue_rt, issue_rd} = {op, rs, rt, rd};
      ok = 1'b0;
      while (!ok) begin
        // judged on settled flags, before the edge that would take it
        ok = ready && (op < `IMD_OP_WPROD || op > `IMD_OP_DQUOT_U || md_ready)
             && ((op != `IMD_OP_MOVE_UPPER && op != `IMD_OP_MOVE_LOWER) || result_ready);
        @(posedge clk_sys);
        #1;
      end
    end
  endtask
endmodule

// [tb/tb_integer_muldiv_datapath.sv]
`timescale 1ns/1ps
`include "imd_regs.vh"
// self-checking bench of the integer execute datapath
module tb_integer_muldiv_datapath;
  logic        clk_sys;
  logic        rst;
  wire         issue_valid, ready, md_ready, result_ready, wb_valid;
  wire  [4:0]  issue_op, issue_rs, issue_rt, issue_rd, wb_rd;
  wire  [63:0] wb_data, upper_result, lower_result;
  integer      n_mismatch, comparisons, n_wb, cyc;
  logic [63:0] exp_gpr [32];     // value each register should receive
  // setup program: {op, rs, rt, rd}, built up from a zeroed register
  logic [19:0] prog [12] = '{{5'h1F, 15'h0000}, {`IMD_OP_NOR, 15'h0001},
    {`IMD_OP_SUB, 15'h0022}, {`IMD_OP_ADD, 15'h0843}, {`IMD_OP_ADD, 15'h0C44},
    {`IMD_OP_SLL, 15'h1085}, {`IMD_OP_SLL, 15'h10A6}, {`IMD_OP_XOR, 15'h1887},
    {`IMD_OP_OR, 15'h1068}, {`IMD_OP_AND, 15'h1C29}, {`IMD_OP_SRL, 15'h04AA},
    {`IMD_OP_SRA, 15'h04AB}};
  logic [63:0] pexp [12] = '{64'h0, 64'hFFFFFFFFFFFFFFFF, 64'h1, 64'h2, 64'h3, 64'h18,
    64'h3000000, 64'h3000003, 64'h3, 64'h3000003, 64'h000000FFFFFFFFFF,
    64'hFFFFFFFFFFFFFFFF};
  imd_datapath u_dut (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_rs(issue_rs), .issue_rt(issue_rt), .issue_rd(issue_rd),
    .ready(ready), .md_ready(md_ready), .result_ready(result_ready), .wb_valid(wb_valid),
    .wb_rd(wb_rd), .wb_data(wb_data), .upper_result(upper_result),
    .lower_result(lower_result));
  imd_pipe_model u_pipe (.clk_sys(clk_sys), .ready(ready), .md_ready(md_ready),
    .result_ready(result_ready), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_rs(issue_rs), .issue_rt(issue_rt), .issue_rd(issue_rd));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  // every register write must carry its worked-out value
  always @(negedge clk_sys) begin
    if (wb_valid === 1'b1) begin
      n_wb = n_wb + 1;
      chk(wb_data, exp_gpr[wb_rd]);
    end
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // one md op: flags each cycle, result registers at its latency
  task md_run(input logic [4:0] op, rs, rt, rd, input int lat, rep, stl,
              input logic [63:0] hi, lo);
    int k;
    begin
      u_pipe.issue(op, rs, rt, rd, 1);
      u_pipe.idle();
      // result reads stay locked after product_to_gpr_op as well
      for (k = 1; k <= lat; k = k + 1) begin
        chk({ready, md_ready, result_ready}, {k > stl, k >= rep, k >= lat - 1});
        if (k == lat) begin
          chk(upper_result, hi);
          chk(lower_result, lo);
        end
        @(posedge clk_sys);
        #1;
      end
    end
  endtask
  // back-to-back dependent alu ops, one per cycle
  task t_alu;
    int i, t0;
    begin
      for (i = 0; i < 12; i = i + 1) begin
        exp_gpr[prog[i][4:0]] = pexp[i];
        u_pipe.issue(prog[i][19:15], prog[i][14:10], prog[i][9:5], prog[i][4:0], 0);
        if (i == 0) t0 = cyc;
      end
      chk(64'(cyc - t0), 64'hB);
      u_pipe.idle();
      repeat (3) @(posedge clk_sys);
      #1;
      chk(64'(n_wb), 64'hC);
    end
  endtask
  task t_mul;
    begin
      md_run(`IMD_OP_WPROD, 4, 4, 0, 3, 2, 0, 64'h0, 64'h9);
      md_run(`IMD_OP_PACC, 4, 4, 0, 3, 2, 0, 64'h0, 64'h12);
      md_run(`IMD_OP_WPROD, 6, 6, 0, 4, 3, 0, 64'h90000, 64'h0);
      md_run(`IMD_OP_PACC_U, 6, 4, 0, 4, 3, 0, 64'h90000, 64'h9000000);
      md_run(`IMD_OP_WPROD_U, 6, 4, 0, 4, 3, 0, 64'h0, 64'h9000000);
      md_run(`IMD_OP_DPROD, 7, 1, 0, 6, 5, 0, 64'hFFFFFFFFFFFFFFFF, 64'hFFFFFFFFFCFFFFFD);
      md_run(`IMD_OP_DPROD_U, 6, 4, 0, 6, 5, 0, 64'h0, 64'h9000000);
    end
  endtask
  task t_div;
    begin
      md_run(`IMD_OP_WQUOT, 7, 5, 0, 36, 36, 0, 64'h3, 64'h200000);
      md_run(`IMD_OP_WQUOT_U, 7, 3, 0, 36, 36, 0, 64'h1, 64'h1800001);
      // zero divisor: all-ones quotient, dividend left as remainder
      md_run(`IMD_OP_WQUOT_U, 7, 0, 0, 36, 36, 0, 64'h3000003, 64'hFFFFFFFFFFFFFFFF);
      md_run(`IMD_OP_DQUOT, 1, 3, 0, 68, 68, 0, 64'hFFFFFFFFFFFFFFFF, 64'h0);
      md_run(`IMD_OP_DQUOT_U, 10, 5, 0, 68, 68, 0, 64'hF, 64'hAAAAAAAAA);
    end
  endtask
  // product straight to a register, result registers untouched
  task t_gpr;
    int w0;
    begin
      w0 = n_wb;
      exp_gpr[12] = 64'h9;
      md_run(`IMD_OP_PROD_GPR, 4, 4, 12, 3, 2, 1, 64'hF, 64'hAAAAAAAAA);
      exp_gpr[13] = 64'h9000000;
      md_run(`IMD_OP_PROD_GPR, 6, 4, 13, 4, 3, 2, 64'hF, 64'hAAAAAAAAA);
      chk(64'(n_wb - w0), 64'h2);
    end
  endtask
  // ops presented early are held off by the interlocks
  task t_interlock;
    int t0, w0;
    begin
      w0 = n_wb;
      exp_gpr[14] = 64'h200000;
      exp_gpr[15] = 64'h3;
      u_pipe.issue(`IMD_OP_WPROD, 4, 4, 0, 1);
      t0 = cyc;
      u_pipe.issue(`IMD_OP_DPROD_U, 6, 4, 0, 0);
      chk(64'(cyc - t0), 64'h2);
      u_pipe.issue(`IMD_OP_WQUOT, 7, 5, 0, 0);
      chk(64'(cyc - t0), 64'h7);
      u_pipe.issue(`IMD_OP_MOVE_LOWER, 0, 0, 14, 0);
      chk(64'(cyc - t0), 64'h2A);
      u_pipe.issue(`IMD_OP_MOVE_UPPER, 0, 0, 15, 0);
      u_pipe.idle();
      repeat (3) @(posedge clk_sys);
      #1;
      chk(64'(n_wb - w0), 64'h2);
    end
  endtask
  // run is far below this span; reaching it means a hang
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_sim();
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    n_wb = 0;
    cyc = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_alu();
    t_mul();
    t_div();
    t_gpr();
    t_interlock();
    end_sim();
  end
endmodule
